// ===== design/vid_fmt_pkg.sv
// Purpose: shared constants and types for the video output formatter
// Assumes: one receive clock domain, plain register port
// Notes:   register offsets and field positions live here only

package vid_fmt_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;     // mode and colour setup
  localparam logic [7:0] STATUS_OFFSET = 8'h04;     // last trs word and line

  localparam int CTRL_MODE_LSB   = 6;               // mode field 9:6
  localparam int CTRL_COLOR_LSB  = 0;               // colour field 2:0
  localparam int STAT_TRS_LSB    = 16;              // trs word 25:16
  localparam int STAT_LINE_LSB   = 0;               // line number 10:0

  localparam logic [3:0]  MODE_SD    = 4'h0;        // standard definition
  localparam logic [3:0]  MODE_HD    = 4'h2;        // high definition
  localparam logic [3:0]  MODE_3G    = 4'h5;        // 3g level a
  localparam logic [2:0]  COLOR_422  = 3'h2;        // ycbcr 4:2:2
  localparam logic [3:0]  MODE_RESET  = 4'h0;       // mode after reset
  localparam logic [2:0]  COLOR_RESET = 3'h0;       // colour after reset

  // ***************************************************************
  // valid vector and mark bit positions
  // ***************************************************************
  localparam int VV_LINE  = 0;                      // line number valid
  localparam int VV_TRS   = 1;                      // timing reference valid
  localparam int VV_ANC   = 5;                      // ancillary word valid
  localparam int VV_VIDEO = 7;                      // video word valid
  localparam int MK_FRAME_FIRST = 7;                // first sample of frame
  localparam int MK_LINE_FIRST  = 6;                // first sample of line
  localparam int MK_LINE_LAST   = 5;                // last sample of line
  localparam int MK_FRAME_LAST  = 4;                // last sample of frame

  localparam logic [15:0] STEP_422 = 16'h0002;      // index step, 4:2:2
  localparam logic [15:0] STEP_444 = 16'h0001;      // index step, 4:4:4
  localparam logic [15:0] INDEX_START = 16'h0000;   // first index of a run

  // ***************************************************************
  // parsed word from the frame parser
  // ***************************************************************
  typedef enum logic [2:0] {
    KIND_EAV,
    KIND_SAV,
    KIND_HORIZONTAL_ANC_SPACE,
    KIND_VERTICAL_ANC_SPACE,
    KIND_VIDEO,
    KIND_OTHER
  } word_kind_e;

  typedef struct packed {
    logic        valid;       // word present this cycle
    word_kind_e  kind;        // what the word is
    logic [39:0] data;        // four 10-bit words, first in 39:30
    logic [10:0] line;        // line number, good alongside eav
    logic        first_line;  // run is on first active line of frame
    logic        last_line;   // run is on last active line of frame
    logic        last_word;   // final word of this run
  } parsed_word_s;

endpackage : vid_fmt_pkg

// ===== design/video_output_formatter.sv
// Purpose: presents trs, line number, ancillary, video, marks and index
// Assumes: parser delivers one parsed word per cycle, synchronous inputs
// Notes:   every output is registered, one cycle behind the parsed word, except the line number, two cycles behind its eav
//
// Behaviour
// - timing reference on trs_word with valid bit 1
// - trs_word holds until next eav or sav
// - line number valid bit 0, cycle after eav shown
// - line number holds until next recovery
// - line number forced zero in sd mode
// - ancillary 40-bit word with valid bit 5
// - first horizontal_anc_space word cycle after eav shown
// - first vertical_anc_space word cycle after sav shown
// - video 40-bit word with valid bit 7
// - video word every cycle from sav to eav
// - marks flag first/last sample, one cycle
// - sample index starts zero, counts per run
// - index step two for 4:2:2, else one
// - mark bits 7,6,5,4 frame/line first/last
// - reserved valid bits zero; bit 0 zero in sd
//
// The register addresses and the address-and-strobe port were chosen for this implementation.

`timescale 1ns/1ps

module video_output_formatter
  import vid_fmt_pkg::*;
(
  input  wire logic         sys_clk,          // 20 mhz receive clock
  input  wire logic         rst_b,            // synchronous reset, low
  input  wire parsed_word_s parsed_in,        // word from the parser
  input  wire logic [7:0]   reg_addr,         // register byte offset
  input  wire logic [31:0]  reg_wdata,        // register write data
  input  wire logic         reg_wr,           // write strobe
  input  wire logic         reg_rd,           // read strobe
  output logic      [31:0]  reg_rdata,        // read data, cycle after strobe
  output logic      [7:0]   valid_vector,     // per-output qualifiers
  output logic      [9:0]   trs_word,         // last eav or sav
  output logic      [10:0]  line_number_out,  // recovered line number
  output logic      [39:0]  anc_word_out,     // ancillary word
  output logic      [39:0]  video_word_out,   // active video word
  output logic      [7:0]   sample_marks,     // first/last sample flags
  output logic      [15:0]  sample_index      // sample number of word
);

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [3:0]  mode_q;        // operating mode
  logic [2:0]  color_q;       // colour coding
  logic [31:0] rdata_q;       // read data register
  logic [7:0]  valid_q;       // valid vector register
  logic [9:0]  trs_q;         // presented trs word
  logic [10:0] line_q;        // presented line number
  logic [10:0] ln_pend_q;     // line number caught with eav
  logic        eav_shown_q;   // eav presented this cycle
  logic [39:0] anc_q;         // ancillary word register
  logic [39:0] video_q;       // video word register
  logic [7:0]  marks_q;       // marks register
  logic [15:0] index_q;       // presented index
  logic [15:0] count_q;       // index of the next word in the run
  logic        first_pend_q;  // next video word opens the line

  // ***************************************************************
  // decode
  // ***************************************************************
  wire         in_v      = parsed_in.valid;
  wire         is_eav    = in_v && (parsed_in.kind == KIND_EAV);
  wire         is_sav    = in_v && (parsed_in.kind == KIND_SAV);
  wire         is_trs    = is_eav || is_sav;
  wire         is_anc    = in_v && ((parsed_in.kind == KIND_HORIZONTAL_ANC_SPACE) ||
                                    (parsed_in.kind == KIND_VERTICAL_ANC_SPACE));
  wire         is_video  = in_v && (parsed_in.kind == KIND_VIDEO);
  wire         sd_mode   = (mode_q == MODE_SD);
  wire [15:0]  step      = (color_q == COLOR_422) ? STEP_422 : STEP_444;
  wire         ctrl_hit  = (reg_addr == CTRL_OFFSET);
  wire         stat_hit  = (reg_addr == STATUS_OFFSET);
  wire         line_show = eav_shown_q && !sd_mode;

  // mark bits for the video word being taken
  wire         mk_lfirst = is_video && first_pend_q;
  wire         mk_llast  = is_video && parsed_in.last_word;
  wire [7:0]   marks_d   = {mk_lfirst && parsed_in.first_line,
                            mk_lfirst,
                            mk_llast,
                            mk_llast && parsed_in.last_line,
                            4'h0};

  // reserved valid bits stay zero by construction
  wire [7:0]   valid_d   = {is_video, 1'b0, is_anc, 3'h0,
                            is_trs, line_show};

  // read data mux, unmapped offsets read zero
  wire [31:0]  ctrl_view = {22'h00_0000, mode_q, 3'h0, color_q};
  wire [31:0]  stat_view = {6'h00, trs_q, 5'h00, line_q};
  wire [31:0]  rdata_d   = !reg_rd  ? 32'h0000_0000 :
                           ctrl_hit ? ctrl_view :
                           stat_hit ? stat_view : 32'h0000_0000;

  // ***************************************************************
  // register port
  // ***************************************************************
  // mode and colour steer line forcing and index step
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      mode_q  <= MODE_RESET;
      color_q <= COLOR_RESET;
    end else if (reg_wr && ctrl_hit) begin
      mode_q  <= reg_wdata[CTRL_MODE_LSB +: 4];
      color_q <= reg_wdata[CTRL_COLOR_LSB +: 3];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ***************************************************************
  // valid vector and marks
  // ***************************************************************
  // valids and marks are pulses; reset holds them low
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      valid_q <= 8'h00;
      marks_q <= 8'h00;
    end else begin
      valid_q <= valid_d;
      marks_q <= marks_d;
    end
  end

  // ***************************************************************
  // timing reference and line number
  // ***************************************************************
  // trs word only moves on a new eav or sav
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trs_q       <= 10'h000;
      eav_shown_q <= 1'b0;
      ln_pend_q   <= 11'h000;
    end else begin
      eav_shown_q <= is_eav;
      if (is_trs) begin
        trs_q <= parsed_in.data[9:0];
      end
      if (is_eav) begin
        ln_pend_q <= parsed_in.line;
      end
    end
  end

  // line number follows eav by two cycles; sd forces zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      line_q <= 11'h000;
    end else if (sd_mode) begin
      line_q <= 11'h000;
    end else if (line_show) begin
      line_q <= ln_pend_q;
    end
  end

  // ***************************************************************
  // ancillary and video data
  // ***************************************************************
  // data registers hold between words; no buffering beyond one stage
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      anc_q   <= 40'h00_0000_0000;
      video_q <= 40'h00_0000_0000;
    end else begin
      if (is_anc) begin
        anc_q <= parsed_in.data;
      end
      if (is_video) begin
        video_q <= parsed_in.data;
      end
    end
  end

  // ***************************************************************
  // sample index
  // ***************************************************************
  // every trs restarts the count, so horizontal_anc_space counts from eav side and
  // vertical_anc_space or video from sav side
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count_q      <= INDEX_START;
      index_q      <= INDEX_START;
      first_pend_q <= 1'b0;
    end else begin
      if (is_trs) begin
        count_q      <= INDEX_START;
        first_pend_q <= is_sav;
      end else if (is_anc || is_video) begin
        index_q      <= count_q;
        count_q      <= count_q + step;
        if (is_video) begin
          first_pend_q <= 1'b0;
        end
      end
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign reg_rdata       = rdata_q;
  assign valid_vector    = valid_q;
  assign trs_word        = trs_q;
  assign line_number_out = line_q;
  assign anc_word_out    = anc_q;
  assign video_word_out  = video_q;
  assign sample_marks    = marks_q;
  assign sample_index    = index_q;

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_trs_present: assert property (@(posedge sys_clk) disable iff (!rst_b)
    is_trs |=> valid_vector[VV_TRS] && (trs_word == $past(parsed_in.data[9:0])))
    else $error("trs word not presented");

  chk_trs_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !valid_vector[VV_TRS] && $past(rst_b) |-> $stable(trs_word))
    else $error("trs word moved without trs");

  chk_line_after_eav: assert property (@(posedge sys_clk) disable iff (!rst_b)
    is_eav && !sd_mode ##1 !sd_mode |=> valid_vector[VV_LINE] &&
      (line_number_out == $past(parsed_in.line, 2)))
    else $error("line number not shown after eav");

  chk_line_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !valid_vector[VV_LINE] && !sd_mode && $past(rst_b) |-> $stable(line_number_out))
    else $error("line number moved without valid");

  chk_sd_line_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sd_mode ##1 sd_mode |-> (line_number_out == 11'h000) && !valid_vector[VV_LINE])
    else $error("line number not zero in sd mode");

  chk_anc_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
    is_anc |=> valid_vector[VV_ANC] && (anc_word_out == $past(parsed_in.data)))
    else $error("ancillary word not presented");

  chk_video_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
    is_video |=> valid_vector[VV_VIDEO] && (video_word_out == $past(parsed_in.data)))
    else $error("video word not presented");

  chk_marks_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sample_marks != 8'h00) |-> valid_vector[VV_VIDEO] ##1
      !(sample_marks[MK_LINE_FIRST] && $past(sample_marks[MK_LINE_FIRST])))
    else $error("mark outside video or held");

  chk_index_start: assert property (@(posedge sys_clk) disable iff (!rst_b)
    valid_vector[VV_TRS] ##1 (valid_vector[VV_VIDEO] || valid_vector[VV_ANC]) |->
      sample_index == INDEX_START)
    else $error("run did not start at index zero");

  chk_index_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    valid_vector[VV_VIDEO] && $past(valid_vector[VV_VIDEO]) && $stable(color_q) |->
      sample_index == 16'($past(sample_index) + step))
    else $error("index step wrong");

  chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (valid_vector[6] == 1'b0) && (valid_vector[4:2] == 3'h0) &&
      (sample_marks[3:0] == 4'h0))
    else $error("reserved bit set");

  chk_reset_quiet: assert property (@(posedge sys_clk)
    !rst_b |=> (valid_vector == 8'h00) && (sample_marks == 8'h00))
    else $error("valid or marks set after reset");

endmodule : video_output_formatter

// ===== testbench/video_output_formatter_tb.sv
// Purpose: self-checking bench for the video output formatter
// Assumes: one word per cycle from the parser, 20 mhz clock
// Notes:   driver queues expected outputs, a monitor pops them

`timescale 1ns/1ps

module video_output_formatter_tb;
  import vid_fmt_pkg::*;

  // ***************************************************************
  // signals and model state
  // ***************************************************************
  typedef struct packed {
    logic [7:0]  vv;   // qualifiers
    logic [9:0]  trs;  // timing word
    logic [10:0] ln;   // line number
    logic [39:0] d;    // anc or video word
    logic [7:0]  mk;   // marks
    logic [15:0] ix;   // sample index
  } note_s;
  logic         sys_clk = 1'b0;
  logic         rst_b   = 1'b0;
  parsed_word_s parsed_in = '0;
  logic [7:0]   reg_addr = 8'h00;
  logic [31:0]  reg_wdata = 32'h0000_0000;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [31:0]  reg_rdata;
  logic [7:0]   valid_vector, sample_marks;
  logic [9:0]   trs_word;
  logic [10:0]  line_number_out;
  logic [39:0]  anc_word_out, video_word_out;
  logic [15:0]  sample_index, vid_cnt, anc_cnt;
  note_s        notes[$];
  note_s        mn;
  int           fail_count = 0, n_checks = 0, nvid = 0, nanc = 0;
  logic [31:0]  x = 32'h0000_0046;
  logic [9:0]   etrs = 10'h000;
  logic [10:0]  eln = 11'h000, lval;
  logic [15:0]  idx, step = STEP_444;
  logic         sd = 1'b1, lpend = 1'b0, first = 1'b0;

  always #25 sys_clk = ~sys_clk;  // 50 ns period

  video_output_formatter dut (.sys_clk(sys_clk), .rst_b(rst_b), .parsed_in(parsed_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .valid_vector(valid_vector), .trs_word(trs_word), .line_number_out(line_number_out),
    .anc_word_out(anc_word_out), .video_word_out(video_word_out), .sample_marks(sample_marks),
    .sample_index(sample_index));
  video_sink sink (.sys_clk(sys_clk), .rst_b(rst_b), .valid_vector(valid_vector),
    .vid_cnt(vid_cnt), .anc_cnt(anc_cnt));

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic chk(logic [63:0] s, logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // one parser word per call, with its expected result queued
  task automatic word(word_kind_e k, logic lw = 1'b0, logic fl = 1'b0, logic ll = 1'b0);
    parsed_word_s w;
    note_s n;
    w = '{1'b1, k, 40'({xs(), xs()}), 11'(xs()), fl, ll, lw};
    @(posedge sys_clk);
    parsed_in <= w;
    n = '0;
    if (lpend) begin
      eln = lval;
      n.vv[VV_LINE] = 1'b1;
    end
    lpend = 1'b0;
    case (k)
      KIND_EAV, KIND_SAV: begin
        etrs = w.data[9:0];
        n.vv[VV_TRS] = 1'b1;
        idx = INDEX_START;
        first = (k == KIND_SAV);
        lpend = (k == KIND_EAV) && !sd;
        lval = w.line;
      end
      KIND_HORIZONTAL_ANC_SPACE, KIND_VERTICAL_ANC_SPACE: begin
        n.vv[VV_ANC] = 1'b1;
        {n.d, n.ix} = {w.data, idx};
        idx += step;
        nanc++;
      end
      KIND_VIDEO: begin
        n.vv[VV_VIDEO] = 1'b1;
        {n.d, n.ix} = {w.data, idx};
        idx += step;
        n.mk[7:4] = {first & fl, first, lw, lw & ll};
        first = 1'b0;
        nvid++;
      end
      default: ;  // no data word comes out; only a pending line number can
    endcase
    {n.trs, n.ln} = {etrs, eln};
    if (n.vv != 8'h00) notes.push_back(n);
  endtask : word

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
    // read data must fall back to zero once its single cycle is over
    @(negedge sys_clk);
    chk(reg_rdata, 32'h0000_0000);
  endtask : rd

  // mode change; sd clears the held line number
  task automatic setm(logic [3:0] m, logic [2:0] c);
    wr(CTRL_OFFSET, (32'(m) << CTRL_MODE_LSB) | 32'(c));
    sd = (m == MODE_SD);
    step = (c == COLOR_422) ? STEP_422 : STEP_444;
    if (sd) eln = 11'h000;
    rd(CTRL_OFFSET, (32'(m) << CTRL_MODE_LSB) | 32'(c));
  endtask : setm

  // one line: eav, horizontal_anc_space run, sav, then video or vertical_anc_space run
  task automatic run(int nh, int nv, logic vertical_anc_space, logic fl, logic ll);
    word(KIND_EAV);
    repeat (nh) word(KIND_HORIZONTAL_ANC_SPACE);
    word(KIND_OTHER);
    word(KIND_SAV);
    for (int i = 0; i < nv; i++) word(vertical_anc_space ? KIND_VERTICAL_ANC_SPACE : KIND_VIDEO, i == nv - 1, fl, ll);
    word(KIND_OTHER);
    rd(STATUS_OFFSET, (32'(etrs) << STAT_TRS_LSB) | 32'(eln));
  endtask : run

  // ***************************************************************
  // monitor: pop the oldest note whenever a result appears
  // ***************************************************************
  always @(negedge sys_clk) begin
    if (rst_b && valid_vector !== 8'h00) begin
      mn = notes.size() > 0 ? notes.pop_front() : '1;
      chk(valid_vector, mn.vv);
      chk(trs_word, mn.trs);
      chk(line_number_out, mn.ln);
      chk(sample_marks, mn.mk);
      if (mn.vv[VV_VIDEO]) chk(video_word_out, mn.d);
      if (mn.vv[VV_ANC]) chk(anc_word_out, mn.d);
      if (mn.vv[VV_ANC] | mn.vv[VV_VIDEO]) chk(sample_index, mn.ix);
    end
  end

  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    setm(MODE_HD, COLOR_422);
    run(3, 4, 1'b0, 1'b1, 1'b0);
    run(0, 3, 1'b1, 1'b0, 1'b0);
    setm(MODE_3G, 3'h1);
    run(1, 5, 1'b0, 1'b0, 1'b1);
    wr(STATUS_OFFSET, 32'hFFFF_FFFF);
    rd(STATUS_OFFSET, (32'(etrs) << STAT_TRS_LSB) | 32'(eln));
    rd(8'h08, 32'h0000_0000);
    setm(MODE_SD, COLOR_422);
    run(2, 4, 1'b0, 1'b1, 1'b1);
    setm(MODE_HD, COLOR_422);
    run(2, 1, 1'b0, 1'b1, 1'b1);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    // reset is synchronous: it only bites at the edge after it drops
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({valid_vector, sample_marks, trs_word, line_number_out, sample_index}, 53'h0);
    {sd, step, etrs, eln} = {1'b1, STEP_444, 10'h000, 11'h000};
    @(posedge sys_clk);
    rst_b <= 1'b1;
    run(1, 2, 1'b0, 1'b0, 1'b0);
    repeat (3) word(KIND_OTHER);
    chk(notes.size(), 0);
    chk({vid_cnt, anc_cnt}, {16'(nvid), 16'(nanc)});
    end_of_test();
  end
endmodule : video_output_formatter_tb

// ===== testbench/video_sink.sv
// Purpose: downstream consumer model that tallies delivered words
// Assumes: qualifier bits are one-cycle pulses on the receive clock
// Notes:   never stalls, because the formatter has no back-pressure

`timescale 1ns/1ps

module video_sink
  import vid_fmt_pkg::*;
(
  input  wire logic        sys_clk,       // receive clock
  input  wire logic        rst_b,         // counts only out of reset
  input  wire logic [7:0]  valid_vector,  // qualifiers from formatter
  output logic      [15:0] vid_cnt,       // video words taken
  output logic      [15:0] anc_cnt        // ancillary words taken
);
  initial begin
    vid_cnt = 16'h0000;
    anc_cnt = 16'h0000;
  end

  // take every qualified video and ancillary word; totals survive a reset for the final tally
  always @(posedge sys_clk) begin
    if (rst_b && valid_vector[VV_VIDEO] === 1'b1) vid_cnt <= vid_cnt + 16'h0001;
    if (rst_b && valid_vector[VV_ANC] === 1'b1) anc_cnt <= anc_cnt + 16'h0001;
  end
endmodule : video_sink
